// ---- clk_switch.sv ----
// system clock enable selector that changes source only on a tick of the old source
`timescale 1ns/1ns
module clk_switch (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic int_tick,
    input  wire logic ext_tick,
    input  wire logic sel_ext,
    output logic      sys_tick,
    output logic      on_ext,
    output logic      busy,
    output logic      done
);
    osc_pkg::sw_state_t state_r;
    logic               old_tick;

    assign old_tick = on_ext ? ext_tick : int_tick;
    // the last old tick passes, the next comes from the new source at its own phase, possibly on the very next cycle
    assign sys_tick = old_tick;
    assign busy     = (state_r == osc_pkg::SW_DRAIN);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= osc_pkg::SW_RUN;
            on_ext  <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_r)
                osc_pkg::SW_RUN:
                begin
                    if (sel_ext != on_ext)
                        state_r <= osc_pkg::SW_DRAIN;
                end
                osc_pkg::SW_DRAIN:
                begin
                    if (sel_ext == on_ext)
                        state_r <= osc_pkg::SW_RUN;
                    else if (old_tick)
                    begin
                        on_ext  <= sel_ext;
                        state_r <= osc_pkg::SW_RUN;
                        done    <= 1'b1;
                    end
                end
                default: state_r <= osc_pkg::SW_RUN;
            endcase
        end
    end

    a_switch_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(on_ext) |-> $past(old_tick) && $past(busy))
        else $error("clock source changed without a tick of the old source");
endmodule

// ---- ext_osc_model.sv ----
// behavioural external oscillator: clock source on the pin plus crystal amplitude detector
`timescale 1ns/1ns
module ext_osc_model #(
    parameter int HALF_NS = 30,
    parameter int AMP_CYC = 100
) (
    input  wire logic                sys_clk,
    input  wire osc_pkg::osc_drive_t osc_drive,
    output logic                     ext_clk_pin,
    output logic                     xtal_amp_ok
);
    int amp_cnt = 0;

    // slower than the system clock, as timer use of the external source requires
    initial
    begin
        ext_clk_pin = 1'b0;
        forever
        begin
            #(HALF_NS);
            // the pin stands still while the drive circuit is off
            ext_clk_pin = osc_drive.enable ? ~ext_clk_pin : 1'b0;
        end
    end

    // amplitude builds up only while driven as a crystal
    always @(posedge sys_clk)
    begin
        if (osc_drive.enable && osc_drive.kind == osc_pkg::EXT_XTAL)
            amp_cnt <= amp_cnt + 1;
        else
            amp_cnt <= 0;
    end

    assign xtal_amp_ok = amp_cnt >= AMP_CYC;
endmodule

// ---- ext_osc_sysclk_ctrl.sv ----
// external oscillator mode control, crystal-valid detection and system clock source selection
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "osc_consts.svh"
module ext_osc_sysclk_ctrl (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`ADDR_W-1:0]  paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                ext_clk_pin,
    input  wire logic                xtal_amp_ok,
    input  wire logic [1:0]          internal_clock_divider,
    output osc_pkg::osc_drive_t      osc_drive,
    output logic                     sysclk_tick,
    output logic                     sysclk_is_ext,
    output logic                     ext_tick,
    output logic                     ext_div8_tick,
    output logic                     irq
);
    localparam int SETTLE = `XTAL_SETTLE_CYC;

    logic                     rst_meta_r;
    logic                     rst_sync_n;
    logic [1:0]               pin_s;
    logic                     ext_s;
    logic                     amp_s;
    logic                     sysclk_source_select;
    logic [2:0]               external_osc_mode;
    logic [2:0]               external_freq_control;
    logic [1:0]               irq_stat_r;
    logic [1:0]               irq_mask_r;
    logic [7:0]               rd_val;
    logic                     rd_err;
    logic [7:0]               prdata_r;
    logic                     err_r;
    logic                     wr_en;
    osc_pkg::ext_kind_t       kind;
    logic                     is_div2;
    logic                     ext_on;
    logic                     ext_prev_r;
    logic                     ext_rise;
    logic                     half_r;
    logic [2:0]               div8_cnt_r;
    logic [2:0]               int_cnt_r;
    logic                     int_tick;
    logic [`SETTLE_W-1:0]     settle_cnt_r;
    logic                     crystal_valid_flag;
    logic                     xvalid_nxt;
    logic                     sw_busy;
    logic                     sw_done;
    logic [1:0]               irq_set;
    logic [1:0]               irq_clr;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    function automatic osc_pkg::ext_kind_t kind_of(input logic [2:0] m);
        osc_pkg::ext_kind_t k;
        k = osc_pkg::EXT_OFF;
        if (m[2:1] == 2'b01)
            k = osc_pkg::EXT_CMOS;
        else if (m == 3'h4)
            k = osc_pkg::EXT_RC;
        else if (m == 3'h5)
            k = osc_pkg::EXT_CAP;
        else if (m[2:1] == 2'b11)
            k = osc_pkg::EXT_XTAL;
        return k;
    endfunction

    function automatic logic [2:0] div_mask(input logic [1:0] d);
        return 3'((4'h1 << d) - 4'h1);
    endfunction

    // reset is released synchronously so all flops leave reset on the same edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    sync2 #(.W(2)) u_pin_sync (
        .clk   (sys_clk),
        .rst_n (rst_sync_n),
        .d     ({xtal_amp_ok, ext_clk_pin}),
        .q     (pin_s)
    );
    assign ext_s = pin_s[0];
    assign amp_s = pin_s[1];

    // bus slave: zero wait states, read data captured in the setup cycle
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign pslverr = psel & penable & err_r;
    assign prdata  = {24'h000000, prdata_r};

    always_comb
    begin
        rd_val = 8'h00;
        rd_err = 1'b0;
        if (hit(paddr, `SYS_CLK_SEL_IDX))
            rd_val = {7'h00, sysclk_source_select};
        else if (hit(paddr, `EXT_OSC_CTRL_IDX))
            rd_val = {crystal_valid_flag, external_osc_mode, 1'b0, external_freq_control};
        else if (hit(paddr, `IRQ_STATUS_IDX))
            rd_val = {6'h00, irq_stat_r};
        else if (hit(paddr, `IRQ_MASK_IDX))
            rd_val = {6'h00, irq_mask_r};
        else
            rd_err = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            prdata_r <= 8'h00;
            err_r    <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= pwrite ? 8'h00 : rd_val;
            err_r    <= rd_err;
        end
    end

    // only bit 0 of the select register is stored; the rest always read back zero
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sysclk_source_select <= 1'(`SYS_CLK_SEL_RST);
        else if (wr_en && hit(paddr, `SYS_CLK_SEL_IDX))
            sysclk_source_select <= pwdata[`SRC_SEL_BIT];
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            external_osc_mode     <= 3'(`EXT_OSC_CTRL_RST >> `MODE_LO);
            external_freq_control <= 3'(`EXT_OSC_CTRL_RST);
        end
        else if (wr_en && hit(paddr, `EXT_OSC_CTRL_IDX))
        begin
            external_osc_mode     <= pwdata[`MODE_HI:`MODE_LO];
            external_freq_control <= pwdata[`FREQ_HI:`FREQ_LO];
        end
    end

    // mode decode and the analog drive settings
    assign kind    = kind_of(external_osc_mode);
    assign is_div2 = external_osc_mode[0] && (kind == osc_pkg::EXT_CMOS || kind == osc_pkg::EXT_XTAL);
    assign ext_on  = (kind != osc_pkg::EXT_OFF);

    // the frequency field means drive range, RC range or K factor depending on kind
    assign osc_drive.enable    = ext_on;
    assign osc_drive.kind      = kind;
    assign osc_drive.div2      = is_div2;
    assign osc_drive.freq_ctrl = ext_on ? external_freq_control : 3'h0;

    // external clock edges, optionally halved
    assign ext_rise = ext_on & ext_s & ~ext_prev_r;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ext_prev_r <= 1'b0;
            half_r     <= 1'b0;
            ext_tick   <= 1'b0;
        end
        else
        begin
            ext_prev_r <= ext_s;
            if (!is_div2)
                half_r <= 1'b0;
            else if (ext_rise)
                half_r <= ~half_r;
            ext_tick <= ext_rise & (~is_div2 | half_r);
        end
    end

    // timer clock: every eighth external tick, already aligned to sys_clk
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            div8_cnt_r    <= 3'h0;
            ext_div8_tick <= 1'b0;
        end
        else
        begin
            if (ext_tick)
                div8_cnt_r <= div8_cnt_r + 3'h1;
            ext_div8_tick <= ext_tick && (div8_cnt_r == 3'(`TIMER_EXT_DIV - 1));
        end
    end

    // internal source: sys_clk divided by two to the power of the internal divider setting, usable at once
    assign int_tick = ((int_cnt_r & div_mask(internal_clock_divider)) == 3'h0);

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            int_cnt_r <= 3'h0;
        else
            int_cnt_r <= int_cnt_r + 3'h1;
    end

    // crystal valid: amplitude must hold for the settle count in a crystal mode
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            settle_cnt_r <= '0;
        else if (kind != osc_pkg::EXT_XTAL || !amp_s)
            settle_cnt_r <= '0;
        else if (settle_cnt_r != `SETTLE_W'(SETTLE))
            settle_cnt_r <= settle_cnt_r + `SETTLE_W'(1);
    end

    assign xvalid_nxt = (kind == osc_pkg::EXT_XTAL) && amp_s && (settle_cnt_r == `SETTLE_W'(SETTLE));

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            crystal_valid_flag <= 1'b0;
        else
            crystal_valid_flag <= xvalid_nxt;
    end

    clk_switch u_switch (
        .clk      (sys_clk),
        .rst_n    (rst_sync_n),
        .int_tick (int_tick),
        .ext_tick (ext_tick),
        .sel_ext  (sysclk_source_select),
        .sys_tick (sysclk_tick),
        .on_ext   (sysclk_is_ext),
        .busy     (sw_busy),
        .done     (sw_done)
    );

    // interrupts: sticky status, write one to clear, a new event beats the clear
    assign irq_set[`IRQ_XVALID_BIT] = xvalid_nxt & ~crystal_valid_flag;
    assign irq_set[`IRQ_SWITCH_BIT] = sw_done;
    assign irq_clr = (wr_en && hit(paddr, `IRQ_STATUS_IDX)) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_stat_r <= `IRQ_RST;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_mask_r <= `IRQ_RST;
        else if (wr_en && hit(paddr, `IRQ_MASK_IDX))
            irq_mask_r <= pwdata[1:0];
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_n);

    a_ctrl_rsvd_zero: assert property (psel && !penable && !pwrite && hit(paddr, `EXT_OSC_CTRL_IDX) |=> prdata[3] == 1'b0)
        else $error("reserved control bit read back non-zero");
    a_sel_rsvd_zero: assert property (psel && !penable && !pwrite && hit(paddr, `SYS_CLK_SEL_IDX) |=> prdata[7:1] == 7'h00)
        else $error("select register unused bits read non-zero");
    a_xvalid_mode_only: assert property (kind != osc_pkg::EXT_XTAL |=> !crystal_valid_flag)
        else $error("crystal valid set outside crystal mode");
    a_xvalid_settle_done: assert property ($rose(crystal_valid_flag) |-> $past(settle_cnt_r) == `SETTLE_W'(SETTLE))
        else $error("crystal valid rose before settle count");
    a_mode_write_lands: assert property (wr_en && hit(paddr, `EXT_OSC_CTRL_IDX) |=> external_osc_mode == $past(pwdata[6:4]))
        else $error("mode field not updated by write");
    a_off_no_ext_tick: assert property (!ext_on ##1 !ext_on |-> !ext_tick)
        else $error("external tick while circuit off");
    a_plain_ext_passes: assert property (ext_rise && !is_div2 |=> ext_tick)
        else $error("undivided external edge lost");
    a_div2_skips: assert property (ext_rise && is_div2 && !half_r |=> !ext_tick)
        else $error("divide-by-two stage passed both edges");
    a_div8_timing: assert property (ext_div8_tick |-> $past(ext_tick) && $past(div8_cnt_r) == 3'h7)
        else $error("timer tick not on eighth external tick");
    a_int_sel_tick: assert property (!sysclk_is_ext |-> sysclk_tick == int_tick)
        else $error("internal source not driving system tick");
    a_xvalid_irq_set: assert property ($rose(crystal_valid_flag) |-> irq_stat_r[`IRQ_XVALID_BIT])
        else $error("valid event did not set status");

    c_xvalid_rise: cover property ($rose(crystal_valid_flag));
    c_switch_to_ext: cover property ($rose(sysclk_is_ext));
    c_div8_tick: cover property (ext_div8_tick && is_div2);
    c_unmapped_err: cover property (pslverr);
endmodule

// ---- osc_consts.svh ----
// register map, field positions, reset values and timing counts of the oscillator control block
// Operation
// - bit 7 reads crystal-valid flag, crystal modes only
// - mode field decodes off, CMOS, RC, capacitor, crystal
// - codes 011, 111 add divide-by-two stage
// - control bit 3 reads zero, software writes zero
// - crystal mode: frequency field picks drive range
// - RC mode: frequency field picks frequency range
// - capacitor mode: frequency field picks K factor
// - hardware sets valid flag once crystal settled
// - internal source selectable right after enable
// - select bit 0: internal, 1: external clock
// - external clock stays available to timers always
// - select register unused/reserved bits read zero
// - external/8 timer clock synchronised to system clock
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

`define ADDR_W            10
`define SYS_CLK_SEL_IDX   8'hA9
`define EXT_OSC_CTRL_IDX  8'hB1
`define IRQ_STATUS_IDX    8'hC0
`define IRQ_MASK_IDX      8'hC1

`define XVALID_BIT        7
`define MODE_HI           6
`define MODE_LO           4
`define FREQ_HI           2
`define FREQ_LO           0
`define SRC_SEL_BIT       0
`define IRQ_XVALID_BIT    0
`define IRQ_SWITCH_BIT    1

`define SYS_CLK_SEL_RST   8'h00
`define EXT_OSC_CTRL_RST  8'h00
`define IRQ_RST           2'h0

`define CLK_PERIOD_NS     10
`define XTAL_SETTLE_NS    20000
`define XTAL_SETTLE_CYC   ((`XTAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W          12
`define TIMER_EXT_DIV     8

`endif

// ---- osc_pkg.sv ----
// types shared by the oscillator control block
package osc_pkg;

    typedef enum logic [2:0] {
        EXT_OFF,
        EXT_CMOS,
        EXT_RC,
        EXT_CAP,
        EXT_XTAL
    } ext_kind_t;

    typedef enum logic {
        SW_RUN,
        SW_DRAIN
    } sw_state_t;

    typedef struct packed {
        logic      enable;
        ext_kind_t kind;
        logic      div2;
        logic [2:0] freq_ctrl;
    } osc_drive_t;

endpackage

// ---- sync2.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the oscillator and system clock select block
`timescale 1ns/1ns
`include "osc_consts.svh"
module testbench;
    localparam logic [`ADDR_W-1:0] A_SEL = {`SYS_CLK_SEL_IDX, 2'b00};
    localparam logic [`ADDR_W-1:0] A_CTL = {`EXT_OSC_CTRL_IDX, 2'b00};
    localparam logic [`ADDR_W-1:0] A_ST  = {`IRQ_STATUS_IDX, 2'b00};
    localparam logic [`ADDR_W-1:0] A_MSK = {`IRQ_MASK_IDX, 2'b00};

    logic                sys_clk = 1'b0;
    logic                rst_n   = 1'b0;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [`ADDR_W-1:0]  paddr   = '0;
    logic [31:0]         pwdata  = '0;
    logic [1:0]          int_div = 2'h2;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                ext_clk_pin;
    logic                xtal_amp_ok;
    logic                sysclk_tick;
    logic                sysclk_is_ext;
    logic                ext_tick;
    logic                ext_div8_tick;
    logic                irq;
    osc_pkg::osc_drive_t osc_drive;
    osc_pkg::ext_kind_t  exp_k;
    logic [31:0]         lfsr = 32'h75B10975;
    logic [31:0]         rd;
    logic                err;
    logic [2:0]          f;
    int                  errors = 0;
    int                  checks_done = 0;
    int                  cycles = 0;
    int                  e_cnt;
    int                  d_cnt;
    int                  s_cnt;

    always #5 sys_clk = ~sys_clk;

    ext_osc_sysclk_ctrl dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_pin(ext_clk_pin), .xtal_amp_ok(xtal_amp_ok), .internal_clock_divider(int_div),
        .osc_drive(osc_drive), .sysclk_tick(sysclk_tick), .sysclk_is_ext(sysclk_is_ext),
        .ext_tick(ext_tick), .ext_div8_tick(ext_div8_tick), .irq(irq)
    );

    ext_osc_model osc (
        .sys_clk(sys_clk), .osc_drive(osc_drive), .ext_clk_pin(ext_clk_pin), .xtal_amp_ok(xtal_amp_ok)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one setup cycle, then access until pready; entered and left right after an edge
    task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic count(input int n);
        e_cnt = 0;
        d_cnt = 0;
        s_cnt = 0;
        repeat (n)
        begin
            @(posedge sys_clk);
            e_cnt += int'(ext_tick);
            d_cnt += int'(ext_div8_tick);
            s_cnt += int'(sysclk_tick);
        end
    endtask

    task automatic wait_src(input logic v);
        for (int n = 0; n < 300 && sysclk_is_ext !== v; n++)
            @(posedge sys_clk);
        // the status flop is set one edge after the source flips
        @(posedge sys_clk);
    endtask

    task complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(0, A_SEL, 0);
        check("sel_reset", rd, 32'h0);
        apb(0, A_CTL, 0);
        check("ctl_reset", rd, 32'h0);
        check("irq_reset", irq, 0);
        apb(1, A_SEL, 32'hC8);
        apb(0, A_SEL, 0);
        check("sel_unused", rd, 32'h0);
        apb(1, A_CTL, 32'h80);
        apb(0, A_CTL, 0);
        check("ctl_bit3_bit7", rd, 32'h0);
        for (int m = 0; m < 8; m++)
        begin
            lfsr = lfsr_next(lfsr);
            f = lfsr[2:0];
            exp_k = m < 2 ? osc_pkg::EXT_OFF : m < 4 ? osc_pkg::EXT_CMOS : m == 4 ? osc_pkg::EXT_RC :
                    m == 5 ? osc_pkg::EXT_CAP : osc_pkg::EXT_XTAL;
            apb(1, A_CTL, {25'h0, m[2:0], 1'b0, f});
            apb(0, A_CTL, 0);
            check("ctl_mode", rd, {25'h0, m[2:0], 1'b0, f});
            check("drive_en", osc_drive.enable, m[2:1] != 2'h0);
            check("drive_kind", osc_drive.kind, exp_k);
            check("drive_div2", osc_drive.div2, m == 3 || m == 7);
            check("drive_freq", osc_drive.freq_ctrl, m[2:1] != 2'h0 ? f : 3'h0);
        end
        apb(1, A_CTL, 32'h00);
        count(200);
        check("ticks_off", e_cnt, 0);
        apb(1, A_CTL, 32'h20);
        count(600);
        check("ext_rate", e_cnt >= 98 && e_cnt <= 102, 1);
        check("div8_rate", d_cnt >= e_cnt / 8 - 1 && d_cnt <= e_cnt / 8 + 1, 1);
        apb(1, A_CTL, 32'h30);
        count(600);
        check("div2_rate", e_cnt >= 48 && e_cnt <= 52, 1);
        apb(1, A_CTL, 32'h20);
        apb(1, A_MSK, 32'h2);
        apb(1, A_SEL, 32'h1);
        wait_src(1'b1);
        check("on_ext", sysclk_is_ext, 1);
        check("irq_switch", irq, 1);
        apb(0, A_ST, 0);
        check("status_switch", rd, 32'h2);
        apb(1, A_ST, 32'h2);
        check("irq_cleared", irq, 0);
        count(300);
        check("ext_sysclk", s_cnt >= e_cnt - 1 && s_cnt <= e_cnt + 1, 1);
        apb(1, A_SEL, 32'h0);
        wait_src(1'b0);
        check("on_int", sysclk_is_ext, 0);
        count(200);
        check("int_sysclk", s_cnt >= 49 && s_cnt <= 51, 1);
        check("ext_kept", e_cnt > 0, 1);
        // every internal divide setting, while the internal source drives the system tick
        for (int d = 0; d < 4; d++)
        begin
            int_div <= 2'(d);
            count(64);
            check("int_div_rate", s_cnt >= (64 >> d) - 1 && s_cnt <= (64 >> d) + 1, 1);
        end
        int_div <= 2'h2;
        apb(1, A_ST, 32'h2);
        apb(1, A_MSK, 32'h0);
        apb(1, A_CTL, 32'h67);
        apb(0, A_CTL, 0);
        check("xtal_early", rd, 32'h67);
        repeat (2500) @(posedge sys_clk);
        apb(0, A_CTL, 0);
        check("xtal_valid", rd, 32'hE7);
        check("irq_masked", irq, 0);
        apb(0, A_ST, 0);
        check("status_xtal", rd, 32'h1);
        apb(1, A_MSK, 32'h1);
        check("irq_unmasked", irq, 1);
        apb(1, A_ST, 32'h1);
        check("irq_w1c", irq, 0);
        apb(1, A_CTL, 32'h47);
        apb(0, A_CTL, 0);
        check("rc_no_valid", rd, 32'h47);
        apb(1, 10'h100, 32'hFF);
        apb(0, 10'h100, 0);
        check("unmapped_err", err, 1);
        check("unmapped_data", rd, 32'h0);
        complete_run();
    end
endmodule
